/* hdio_consts.vh */
`ifndef HDIO_CONSTS_VH
`define HDIO_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define HDIO_OFS_PATTERN   12'h000
`define HDIO_OFS_CONFIG    12'h004
`define HDIO_OFS_CONTROL   12'h008
`define HDIO_OFS_STATUS    12'h00C
`define HDIO_OFS_CLR_DELAY 12'h010

// ****************************************************************
// Configuration field positions
// ****************************************************************
`define HDIO_CFG_WIDTH3    0
`define HDIO_CFG_L4_ENABLE 1
`define HDIO_CFG_L4_BUSY   2
`define HDIO_CFG_POL_HIGH  3
`define HDIO_CFG_ARM_LO    4
`define HDIO_CFG_ARM_HI    5
`define HDIO_CFG_LOCK_EN   6
`define HDIO_CFG_AUTO_CLR  7

// ****************************************************************
// Control field positions (write one to act)
// ****************************************************************
`define HDIO_CTL_OUT_ON    0
`define HDIO_CTL_OUT_OFF   1
`define HDIO_CTL_CLEAR     2
`define HDIO_CTL_DONE      3
`define HDIO_CTL_BUSY_SET  4
`define HDIO_CTL_BUSY_CLR  5

// ****************************************************************
// Status field positions
// ****************************************************************
`define HDIO_ST_OUT_ON     0
`define HDIO_ST_LOCK_OPEN  1
`define HDIO_ST_LOCK_TRIP  2
`define HDIO_ST_ARMED      3
`define HDIO_ST_BUSY       4

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define HDIO_RST_CONFIG    8'h30
`define HDIO_RST_DELAY     16'h0000
`define HDIO_CLK_NS        25
`define HDIO_DONE_NS       1000
`define HDIO_DONE_CYC      ((`HDIO_DONE_NS + `HDIO_CLK_NS - 1) / `HDIO_CLK_NS)
`define HDIO_TICK_NS       1000
`define HDIO_TICK_CYC      (`HDIO_TICK_NS / `HDIO_CLK_NS)

`endif

/* hdio_edge_sync.v */
// ****************************************************************
// Two-stage synchroniser with edge detection on the settled stage
// ****************************************************************
module hdio_edge_sync
(
    // Clock and reset
    input  wire clk,
    input  wire sys_rst,
    // Asynchronous line and its clean views
    input  wire async_in,
    output reg  level,
    output wire rise,
    output wire fall
);

    reg       meta;
    reg       last;
    reg [2:0] fill;

    // The first stage feeds only the second, so no decision sees a metastable value.
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta  <= 1'b1;
            level <= 1'b1;
            last  <= 1'b1;
            fill  <= 3'b000;
        end
        else
        begin
            meta  <= async_in;
            level <= meta;
            last  <= level;
            fill  <= {fill[1:0], 1'b1};
        end
    end

    // Edges are taken from settled stages only, and only once both hold real samples.
    // The pin may idle at either level, so the reset value must never pose as an edge.
    assign rise = fill[2] & level & ~last;
    assign fall = fill[2] & ~level & last;

endmodule

/* hdio_port.v */
// Operation
// - Four output lines each driven high or low by the programmed pattern.
// - Pattern value maps in binary, line 1 least significant, values 0 to 15.
// - Line 4 may carry a test-done pulse or busy level instead.
// - Falling arm event: a low pulse on start input begins the test.
// - Rising arm event: a high pulse on start input begins the test.
// - Both-edge arm event: either pulse begins the test.
// - With interlock enabled, output turns on only while interlock line low.
// - Interlock line high while enabled turns main output off, high impedance.
// - After shutoff, output returns only on line low plus fresh on request.
// - Port width selectable as three or four bits.
// - Line 4 mode done or busy, with selectable active polarity.
// - Auto-clear returns output lines to cleared state after programmable delay.
// - A setting enables or disables the interlock function.
`include "hdio_consts.vh"

module hdio_port
#(
    parameter DELAY_W = 16
)
(
    // Clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    // Handler lines
    output reg  [3:0]  out_lines,
    input  wire        test_start_input,
    input  wire        interlock_n_in,
    // Instrument side
    output reg         test_start_pulse,
    output reg         main_output_on
);

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    // Register state, and the write held over from its address phase.
    reg        wr_pend;
    reg [11:0] wr_addr;
    reg [7:0]  config_r;
    reg [3:0]  pattern;
    reg [DELAY_W-1:0] clr_delay;
    reg        lock_trip;
    reg        busy;
    reg        armed;
    wire       lock_level;
    wire       start_rise;
    wire       start_fall;
    // Control bits act only in the data phase of a write to the control offset.
    wire       addr_ok = hsel & hready & htrans[1];
    wire [5:0] ctl = (wr_pend && wr_addr == `HDIO_OFS_CONTROL) ? hwdata[5:0] : 6'h00;

    // The slave never waits and never errors.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Writes complete in the data phase; reads are registered for the data phase.
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
            hrdata  <= 32'h0000_0000;
        end
        else
        begin
            wr_pend <= addr_ok & hwrite;
            wr_addr <= haddr;
            if (addr_ok && !hwrite)
            begin
                case (haddr)
                    `HDIO_OFS_PATTERN:   hrdata <= {28'h000_0000, pattern};
                    `HDIO_OFS_CONFIG:    hrdata <= {24'h00_0000, config_r};
                    `HDIO_OFS_STATUS:    hrdata <= {27'h000_0000, busy, armed, lock_trip,
                                                    lock_level, main_output_on};
                    `HDIO_OFS_CLR_DELAY: hrdata <= {{(32-DELAY_W){1'b0}}, clr_delay};
                    default:             hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    hdio_edge_sync u_start
    (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in (test_start_input),
        .level    (),
        .rise     (start_rise),
        .fall     (start_fall)
    );

    // The interlock needs only its settled level; its edges are left unused.
    hdio_edge_sync u_lock
    (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in (interlock_n_in),
        .level    (lock_level),
        .rise     (),
        .fall     ()
    );

    // ****************************************************************
    // Configuration and pattern registers
    // ****************************************************************
    // Mode decode; the line 4 alternative has no meaning in three-bit mode.
    wire width3 = config_r[`HDIO_CFG_WIDTH3];
    wire l4_alt = config_r[`HDIO_CFG_L4_ENABLE] & ~width3;
    wire pat_wr = wr_pend && wr_addr == `HDIO_OFS_PATTERN;
    // A refused value is ignored entirely: it neither loads nor restarts the clear delay.
    wire pat_ok = pat_wr && hwdata[31:4] == 28'h000_0000 && !(width3 && hwdata[3]);
    reg [DELAY_W-1:0] clr_cnt;
    reg [5:0]  tick_cnt;
    reg        clr_run;

    // An out-of-range value in three-bit mode is refused and the pattern is kept.
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            config_r  <= `HDIO_RST_CONFIG;
            pattern   <= 4'h0;
            clr_delay <= `HDIO_RST_DELAY;
        end
        else
        begin
            if (wr_pend && wr_addr == `HDIO_OFS_CONFIG)
                config_r <= hwdata[7:0];
            if (wr_pend && wr_addr == `HDIO_OFS_CLR_DELAY)
                clr_delay <= hwdata[DELAY_W-1:0];
            if (pat_ok)
                pattern <= hwdata[3:0];
            else if (ctl[`HDIO_CTL_CLEAR] || (clr_run && clr_cnt == {DELAY_W{1'b0}}
                                               && tick_cnt == 6'd0))
                pattern <= 4'h0;
        end
    end

    // ****************************************************************
    // Auto-clear timer, counted in microsecond ticks
    // ****************************************************************
    // Count limits are cut from full-width integers to the six-bit counters on purpose.
    localparam integer TICK_FULL = `HDIO_TICK_CYC - 1;
    localparam [5:0]   TICK_LAST = TICK_FULL[5:0];

    // A new pattern restarts the delay; it fires once, then idles.
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            clr_run  <= 1'b0;
            clr_cnt  <= {DELAY_W{1'b0}};
            tick_cnt <= 6'd0;
        end
        else if (pat_ok && config_r[`HDIO_CFG_AUTO_CLR])
        begin
            clr_run  <= 1'b1;
            clr_cnt  <= clr_delay;
            tick_cnt <= TICK_LAST;
        end
        else if (clr_run)
        begin
            if (tick_cnt != 6'd0)
                tick_cnt <= tick_cnt - 6'd1;
            else if (clr_cnt != {DELAY_W{1'b0}})
            begin
                clr_cnt  <= clr_cnt - {{(DELAY_W-1){1'b0}}, 1'b1};
                tick_cnt <= TICK_LAST;
            end
            else
                clr_run <= 1'b0;
        end
    end

    // ****************************************************************
    // Line 4 alternative: done pulse or busy level
    // ****************************************************************
    localparam integer DONE_FULL = `HDIO_DONE_CYC - 1;
    localparam [5:0]   DONE_LAST = DONE_FULL[5:0];
    reg [5:0] done_cnt;
    reg       done_act;

    // The done pulse has a fixed width so the handler always sees it.
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            done_act <= 1'b0;
            done_cnt <= 6'd0;
            busy     <= 1'b0;
        end
        else
        begin
            if (ctl[`HDIO_CTL_DONE])
            begin
                done_act <= 1'b1;
                done_cnt <= DONE_LAST;
            end
            else if (done_cnt != 6'd0)
                done_cnt <= done_cnt - 6'd1;
            else
                done_act <= 1'b0;
            // Busy set wins over a clear carried in the same write.
            if (ctl[`HDIO_CTL_BUSY_SET])
                busy <= 1'b1;
            else if (ctl[`HDIO_CTL_BUSY_CLR])
                busy <= 1'b0;
        end
    end

    // Line drive, with line 4 optionally handed to the done or busy signal.
    wire l4_act = config_r[`HDIO_CFG_L4_BUSY] ? busy : done_act;
    wire l4_lvl = config_r[`HDIO_CFG_POL_HIGH] ? l4_act : ~l4_act;

    // Lines are registered so the handler never sees decode glitches.
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            out_lines <= 4'h0;
        else
        begin
            out_lines[2:0] <= pattern[2:0];
            out_lines[3]   <= l4_alt ? l4_lvl : (pattern[3] & ~width3);
        end
    end

    // ****************************************************************
    // Start-of-test arm detection
    // ****************************************************************
    wire arm_lo = config_r[`HDIO_CFG_ARM_LO];
    wire arm_hi = config_r[`HDIO_CFG_ARM_HI];
    // A low pulse is seen at its falling edge, a high pulse at its rising edge.
    wire start_hit = (arm_lo & start_fall) | (arm_hi & start_rise);

    // The start pulse is registered and lasts exactly one cycle per detected edge.
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            test_start_pulse <= 1'b0;
            armed            <= 1'b0;
        end
        else
        begin
            test_start_pulse <= start_hit;
            // Set wins over a simultaneous software clear via done.
            if (start_hit)
                armed <= 1'b1;
            else if (ctl[`HDIO_CTL_DONE])
                armed <= 1'b0;
        end
    end

    // ****************************************************************
    // Main output and fixture interlock
    // ****************************************************************
    // With the interlock disabled the lid line is only reported, never obeyed.
    wire lock_en = config_r[`HDIO_CFG_LOCK_EN];

    // Shutoff takes priority; only a fresh on request after the lid closes restores.
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            main_output_on <= 1'b0;
            lock_trip      <= 1'b0;
        end
        else if (lock_en && lock_level)
        begin
            main_output_on <= 1'b0;
            lock_trip      <= lock_trip | main_output_on | ctl[`HDIO_CTL_OUT_ON];
        end
        else if (ctl[`HDIO_CTL_OUT_ON])
        begin
            main_output_on <= 1'b1;
            lock_trip      <= 1'b0;
        end
        else if (ctl[`HDIO_CTL_OUT_OFF])
            main_output_on <= 1'b0;
    end

endmodule

/* hdio_fixture.sv */
// ********
// Handler and fixture model
// ********
module hdio_fixture
(
    // Clock and bench commands
    input  wire logic clk,
    input  wire logic pulse_req,
    input  wire logic idle_level,
    input  wire logic lid_open,
    // Lines into the port
    output logic      test_start_input,
    output logic      interlock_n_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] width_cnt;
    initial
    begin
        width_cnt = 4'h0;
        test_start_input = 1'b0;
        interlock_n_in = 1'b0;
    end
    // Clean single edges only, since the port reacts to every edge it sees.
    always @(posedge clk)
    begin
        interlock_n_in <= lid_open;
        if (width_cnt != 4'h0)
            width_cnt <= width_cnt - 4'h1;
        else if (pulse_req)
            width_cnt <= 4'h8;
        test_start_input <= idle_level ^ (width_cnt > 4'h1 || pulse_req && width_cnt == 4'h0);
    end
endmodule

/* hdio_port_chk.sv */
// ********
// Port behaviour checker
// ********
module hdio_port_chk
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // Bus
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // Handler and instrument lines
    input wire logic [3:0]  out_lines,
    input wire logic        test_start_input,
    input wire logic        interlock_n_in,
    input wire logic        test_start_pulse,
    input wire logic        main_output_on
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic        wr_q;
    logic [11:0] adr_q;
    logic [7:0]  cfg;
    // Shadow of the configuration word, so properties know the mode.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_q  <= 1'b0;
            adr_q <= 12'h000;
            cfg   <= 8'h30;
        end
        else if (hready)
        begin
            wr_q  <= hsel && htrans[1] && hwrite;
            adr_q <= haddr;
            if (wr_q && adr_q == 12'h004)
                cfg <= hwdata[7:0];
        end
    end
    // Auto-clear and line-4 modes would blur the plain pattern relation.
    wire pat_wr = wr_q && adr_q == 12'h000 && !cfg[7] && !cfg[1];
    wire done_wr = wr_q && adr_q == 12'h008 && hwdata[3] && cfg[2:0] == 3'b010;
    AST_PATTERN: assert property (
        pat_wr && !cfg[0] && hwdata < 32'd16 |-> ##2 {28'h0, out_lines} == $past(hwdata, 2))
        else $error("pattern not on lines");
    AST_NARROW: assert property (
        pat_wr && cfg[0] |-> ##2 !out_lines[3] && ($past(hwdata, 2) > 32'd7
        || {29'h0, out_lines[2:0]} == $past(hwdata, 2))) else $error("narrow mode wrong");
    AST_RANGE: assert property (
        pat_wr && hwdata > (cfg[0] ? 32'd7 : 32'd15) |=> $stable(out_lines)[*2])
        else $error("out of range pattern taken");
    AST_DONE: assert property (done_wr |-> ##2 out_lines[3] == cfg[3])
        else $error("done pulse missing");
    AST_PULSE_ONE: assert property (test_start_pulse |=> !test_start_pulse)
        else $error("start pulse too long");
    AST_PULSE_CAUSE: assert property (
        test_start_pulse |-> $past(test_start_input, 1) != $past(test_start_input, 6))
        else $error("start pulse without edge");
    AST_SYNC: assert property ($changed(test_start_input) |=> !test_start_pulse[*2])
        else $error("start edge not synchronised");
    AST_ON_CAUSE: assert property (
        $rose(main_output_on) |-> $past(wr_q, 1) || $past(wr_q, 2))
        else $error("output on without request");
    AST_LOCK_DROP: assert property ((cfg[6] && interlock_n_in)[*7] |-> !main_output_on)
        else $error("output kept on with lid open");
    AST_LOCK_REFUSE: assert property (
        $rose(main_output_on) |-> !(cfg[6] && $past(interlock_n_in, 1)
        && $past(interlock_n_in, 6))) else $error("output on with lid open");
    cover property (test_start_pulse);
    cover property ($fell(main_output_on));
    cover property (done_wr);
endmodule

bind hdio_port hdio_port_chk u_chk
(
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .out_lines(out_lines),
    .test_start_input(test_start_input), .interlock_n_in(interlock_n_in),
    .test_start_pulse(test_start_pulse), .main_output_on(main_output_on)
);

/* hdio_port_test.sv */
`include "hdio_consts.vh"
// ********
// Port testbench
// ********
module hdio_port_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SETTLE = 4000; // Lid settling, 100 us.
    localparam int LIMIT  = 60000;
    logic        clk, sys_rst, hsel, hwrite, pulse_req, idle_level, lid_open;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [11:0] haddr;
    logic [31:0] hwdata, rd;
    logic [7:0]  cfg;
    logic [3:0]  lines;
    wire         hreadyout, hresp, tsi, lock_n, test_start_pulse, main_output_on;
    wire [31:0]  hrdata;
    wire [3:0]   out_lines;
    integer      seed;
    int          mismatches, total_checks, cycles, pulses, v;

    hdio_port #(.DELAY_W(16)) DUT (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .out_lines(out_lines), .test_start_input(tsi), .interlock_n_in(lock_n),
        .test_start_pulse(test_start_pulse), .main_output_on(main_output_on));
    hdio_fixture fix (.clk(clk), .pulse_req(pulse_req), .idle_level(idle_level),
        .lid_open(lid_open), .test_start_input(tsi), .interlock_n_in(lock_n));

    // Free-running 40 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Cycle budget and start-detection count.
    always @(posedge clk)
    begin
        cycles++;
        if (test_start_pulse === 1'b1)
            pulses++;
        if (cycles == LIMIT)
        begin
            mismatches++;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want)
        begin
            mismatches++;
            $display("ERROR %0t: seen %h want %h", $time, seen, want);
        end
    endtask

    // One single transfer; waits on ready rather than assuming latency.
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= a;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic gap(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic lid(input logic open);
        @(posedge clk);
        lid_open <= open;
        gap(SETTLE);
    endtask

    function automatic logic [3:0] exp_lines(input logic [7:0] c, input logic [3:0] old,
        input int val);
        if (val > (c[0] ? 7 : 15))
            return old & (c[0] ? 4'h7 : 4'hf);
        return val[3:0];
    endfunction

    // Main sequence.
    initial
    begin
        seed = 32'hb26c_6401;
        {hsel, hwrite, pulse_req, idle_level, lid_open} = 5'h00;
        htrans = 2'b00;
        hsize = 3'b010;
        haddr = 12'h000;
        hwdata = 32'h0000_0000;
        lines = 4'h0;
        sys_rst = 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        gap(0);
        check(32'(out_lines), 32'h0000_0000);
        bus(1'b0, `HDIO_OFS_CONFIG, 32'h0000_0000);
        check(rd, 32'h0000_0030);
        for (int m = 0; m < 2; m++)
        begin
            cfg = m ? 8'h31 : 8'h30;
            bus(1'b1, `HDIO_OFS_CONFIG, 32'(cfg));
            for (int i = 0; i < 12; i++)
            begin
                v = (i == 0) ? 16 : (i == 1) ? 15 : (i == 2) ? 8 : {$random(seed)} % 20;
                bus(1'b1, `HDIO_OFS_PATTERN, 32'(v));
                lines = exp_lines(cfg, lines, v);
                gap(1);
                check(32'(out_lines), 32'(lines));
            end
        end
        for (int m = 0; m < 8; m++)
        begin
            @(posedge clk);
            idle_level <= m[2];
            bus(1'b1, `HDIO_OFS_CONFIG, 32'(m[1:0]) << 4);
            gap(12);
            pulses = 0;
            @(posedge clk);
            pulse_req <= 1'b1;
            @(posedge clk);
            pulse_req <= 1'b0;
            gap(24);
            check(32'(pulses), 32'(m[0]) + 32'(m[1]));
        end
        bus(1'b1, `HDIO_OFS_CONFIG, 32'h0000_003a);
        bus(1'b1, `HDIO_OFS_CONTROL, 32'h0000_0008);
        gap(38);
        check(32'(out_lines[3]), 32'h0000_0001);
        gap(3);
        check(32'(out_lines[3]), 32'h0000_0000);
        bus(1'b1, `HDIO_OFS_CONFIG, 32'h0000_0036);
        for (int i = 0; i < 3; i++)
        begin
            if (i > 0)
                bus(1'b1, `HDIO_OFS_CONTROL, 32'h0000_0008 << i);
            gap(1);
            check(32'(out_lines[3]), 32'(i != 1));
        end
        bus(1'b1, `HDIO_OFS_CONFIG, 32'h0000_0070);
        for (int i = 0; i < 6; i++)
        begin
            if (i == 1 || i == 3)
                lid(i == 1);
            if (i == 5)
                bus(1'b1, `HDIO_OFS_CONFIG, 32'h0000_0030);
            bus(1'b1, `HDIO_OFS_CONTROL, 32'h0000_0001);
            gap(1);
            check(32'(main_output_on), 32'(i != 1 && i != 2));
        end
        bus(1'b0, `HDIO_OFS_STATUS, 32'h0000_0000);
        check(rd, 32'h0000_0001);
        lid(1'b1);
        check(32'(main_output_on), 32'h0000_0001);
        bus(1'b1, `HDIO_OFS_CLR_DELAY, 32'h0000_0001);
        bus(1'b1, `HDIO_OFS_CONFIG, 32'h0000_00b0);
        bus(1'b1, `HDIO_OFS_PATTERN, 32'h0000_0005);
        gap(60);
        check(32'(out_lines), 32'h0000_0005);
        gap(40);
        check(32'(out_lines), 32'h0000_0000);
        bus(1'b0, 12'h020, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        check(32'(hresp), 32'h0000_0000);
        complete_run();
    end
endmodule
